/* logic/dtc_top.v */
// dual timer/counter with mode register and avalon-mm register slave
`default_nettype none
`include "dtc_defs.vh"
module dtc_top
(
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_n_i,
	// avalon-mm slave
	input  wire [7:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// external pins
	input  wire        timer0_event_input_i,
	input  wire        timer1_event_input_i,
	input  wire        ext_irq_pin_a_i,
	input  wire        ext_irq_pin_b_i,
	// interrupt vector acknowledge from the core
	input  wire        timer0_vector_ack_i,
	input  wire        timer1_vector_ack_i,
	// overflow flags and unit 1 overflow pulse
	output wire        timer0_overflow_flag_o,
	output wire        timer1_overflow_flag_o,
	output wire        timer1_overflow_pulse_o
);
	reg  [7:0] timer_mode_select_q;
	reg        timer0_run_q;
	reg        timer1_run_q;
	reg        timer0_overflow_flag_q;
	reg        timer1_overflow_flag_q;
	reg        ev0_q;
	reg        ev1_q;
	reg        rd_ack_q;
	wire [7:0] low0;
	wire [7:0] high0;
	wire [7:0] low1;
	wire [7:0] high1;
	wire       ovl0;
	wire       ovh0;
	wire       ovl1;
	wire       ovh1;

	wire       timer1_pin_gating    = timer_mode_select_q[`DTC_MODE_TIMER1_PIN_GATING];
	wire       timer1_source_select = timer_mode_select_q[`DTC_MODE_SRC1];
	wire [1:0] timer1_mode          = {timer_mode_select_q[`DTC_MODE_M1_HI],
	                                   timer_mode_select_q[`DTC_MODE_M1_LO]};
	wire       timer0_pin_gating    = timer_mode_select_q[`DTC_MODE_TIMER0_PIN_GATING];
	wire       timer0_source_select = timer_mode_select_q[`DTC_MODE_SRC0];
	wire [1:0] timer0_mode          = {timer_mode_select_q[`DTC_MODE_M0_HI],
	                                   timer_mode_select_q[`DTC_MODE_M0_LO]};
	wire       split0 = (timer0_mode == `DTC_M_SPLIT);

	// read data are registered, so a read waits one cycle; writes never wait
	wire rd_first = avs_read_i && !rd_ack_q;
	assign avs_waitrequest_o = rd_first;
	wire wr_go = avs_write_i && avs_byteenable_i[0];

	function sel;
		input [7:0] adr;
		input [7:0] ofs;
		begin
			sel = (adr == ofs);
		end
	endfunction

	// enable: run bit, and pin high when gated
	function unit_en;
		input run;
		input gate;
		input pin;
		begin
			unit_en = run && (!gate || pin);
		end
	endfunction

	wire en0 = unit_en(timer0_run_q, timer0_pin_gating, ext_irq_pin_a_i);
	wire en1 = unit_en(timer1_run_q, timer1_pin_gating, ext_irq_pin_b_i);

	// pins are sampled once per clock; a falling pair of samples is one event
	wire fall0 = ev0_q && !timer0_event_input_i;
	wire fall1 = ev1_q && !timer1_event_input_i;

	wire tick0 = en0 && (timer0_source_select ? fall0 : 1'b1);
	// unit 1 mode 11 holds its count
	wire tick1 = en1 && (timer1_mode != `DTC_M_SPLIT) &&
	             (timer1_source_select ? fall1 : 1'b1);
	wire tick0h = split0 && timer1_run_q;

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ev0_q <= 1'b0;
			ev1_q <= 1'b0;
		end
		else
		begin
			ev0_q <= timer0_event_input_i;
			ev1_q <= timer1_event_input_i;
		end
	end

	dtc_unit u_unit0
	(
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.mode_i      (timer0_mode),
		.low_tick_i  (tick0),
		.high_tick_i (tick0h),
		.split_i     (split0),
		.wr_low_i    (wr_go && sel(avs_address_i, `DTC_OFS_LOW0)),
		.wr_high_i   (wr_go && sel(avs_address_i, `DTC_OFS_HIGH0)),
		.wdata_i     (avs_writedata_i[7:0]),
		.low_q_o     (low0),
		.high_q_o    (high0),
		.ovf_low_o   (ovl0),
		.ovf_high_o  (ovh0)
	);

	dtc_unit u_unit1
	(
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.mode_i      (timer1_mode),
		.low_tick_i  (tick1),
		.high_tick_i (1'b0),
		.split_i     (1'b0),
		.wr_low_i    (wr_go && sel(avs_address_i, `DTC_OFS_LOW1)),
		.wr_high_i   (wr_go && sel(avs_address_i, `DTC_OFS_HIGH1)),
		.wdata_i     (avs_writedata_i[7:0]),
		.low_q_o     (low1),
		.high_q_o    (high1),
		.ovf_low_o   (ovl1),
		.ovf_high_o  (ovh1)
	);

	wire set0 = split0 ? ovl0 : (ovl0 || ovh0);
	wire set1 = split0 ? (ovh0 || ovl1 || ovh1) : (ovl1 || ovh1);
	assign timer1_overflow_pulse_o = ovl1 || ovh1;

	wire wr_ctrl = wr_go && sel(avs_address_i, `DTC_OFS_CTRL);

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			timer_mode_select_q    <= `DTC_MODE_RESET;
			timer0_run_q           <= 1'b0;
			timer1_run_q           <= 1'b0;
			timer0_overflow_flag_q <= 1'b0;
			timer1_overflow_flag_q <= 1'b0;
		end
		else
		begin
			if (wr_go && sel(avs_address_i, `DTC_OFS_MODE))
				timer_mode_select_q <= avs_writedata_i[7:0];
			if (wr_ctrl)
			begin
				timer0_run_q <= avs_writedata_i[`DTC_CTRL_RUN0];
				timer1_run_q <= avs_writedata_i[`DTC_CTRL_RUN1];
			end
			// a new overflow beats a same-cycle acknowledge or write
			if (set0)
				timer0_overflow_flag_q <= 1'b1;
			else if (timer0_vector_ack_i)
				timer0_overflow_flag_q <= 1'b0;
			else if (wr_ctrl)
				timer0_overflow_flag_q <= avs_writedata_i[`DTC_CTRL_OVF0];
			if (set1)
				timer1_overflow_flag_q <= 1'b1;
			else if (timer1_vector_ack_i)
				timer1_overflow_flag_q <= 1'b0;
			else if (wr_ctrl)
				timer1_overflow_flag_q <= avs_writedata_i[`DTC_CTRL_OVF1];
		end
	end

	assign timer0_overflow_flag_o = timer0_overflow_flag_q;
	assign timer1_overflow_flag_o = timer1_overflow_flag_q;

	// loaded in the wait cycle, standing when waitrequest drops, held until next read
	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			avs_readdata_o <= `DTC_UNMAPPED_RD;
		else if (rd_first)
		begin
			case (avs_address_i)
			`DTC_OFS_CTRL:
				avs_readdata_o <= {24'h000000, timer1_overflow_flag_q, timer1_run_q,
				                   timer0_overflow_flag_q, timer0_run_q, 4'h0};
			`DTC_OFS_MODE:
				avs_readdata_o <= {24'h000000, timer_mode_select_q};
			`DTC_OFS_LOW0:
				avs_readdata_o <= {24'h000000, low0};
			`DTC_OFS_LOW1:
				avs_readdata_o <= {24'h000000, low1};
			`DTC_OFS_HIGH0:
				avs_readdata_o <= {24'h000000, high0};
			`DTC_OFS_HIGH1:
				avs_readdata_o <= {24'h000000, high1};
			default:
				avs_readdata_o <= `DTC_UNMAPPED_RD;
			endcase
		end
	end

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_ack_q <= 1'b0;
		else
			rd_ack_q <= rd_first;
	end
endmodule
`default_nettype wire

/* logic/dtc_defs.vh */
// register map, field positions and reset values for the dual timer/counter
// How it works
// - timer1_pin_gating set: unit 1 runs when pin b high plus run
// - timer1_pin_gating clear: unit 1 runs on run bit
// - timer0_pin_gating set needs pin a high plus run
// - source1 picks event pin or core clock
// - source0 picks event pin or core clock
// - unit1 mode 00 prescaled; mode 11 holds count
// - unit1 mode 01 is cascaded 16-bit counter
// - unit1 mode 10 low byte auto-reloads from high
// - unit0 mode 00 high byte behind 5-bit prescaler
// - unit0 mode 01 is cascaded 16-bit counter
// - unit0 mode 10 low byte auto-reloads from high
// - unit0 split: low byte uses unit0 controls
// - unit0 split: high byte clock only, run1 enabled
// - mode register resets to all zero
// - timer mode counts once per core clock
// - event counts on high-then-low pin samples
// - overflow flags set; cleared on vector acknowledge
// - run bits start and stop each unit
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
`define DTC_OFS_CTRL      8'h88
`define DTC_OFS_MODE      8'h89
`define DTC_OFS_LOW0      8'h8a
`define DTC_OFS_LOW1      8'h8b
`define DTC_OFS_HIGH0     8'h8c
`define DTC_OFS_HIGH1     8'h8d
`define DTC_CTRL_OVF1     7
`define DTC_CTRL_RUN1     6
`define DTC_CTRL_OVF0     5
`define DTC_CTRL_RUN0     4
`define DTC_MODE_TIMER1_PIN_GATING    7
`define DTC_MODE_SRC1     6
`define DTC_MODE_M1_HI    5
`define DTC_MODE_M1_LO    4
`define DTC_MODE_TIMER0_PIN_GATING    3
`define DTC_MODE_SRC0     2
`define DTC_MODE_M0_HI    1
`define DTC_MODE_M0_LO    0
`define DTC_MODE_RESET    8'h00
`define DTC_CTRL_RESET    8'h00
`define DTC_CNT_RESET     8'h00
`define DTC_PRESC_MAX     8'h1f
`define DTC_M_PRESC       2'b00
`define DTC_M_WIDE        2'b01
`define DTC_M_RELOAD      2'b10
`define DTC_M_SPLIT       2'b11
`define DTC_UNMAPPED_RD   32'h0000_0000
`endif

/* logic/dtc_unit.v */
// one 16-bit timer/counter unit: low and high byte with mode-dependent stepping
`default_nettype none
`include "dtc_defs.vh"
module dtc_unit
(
	// clock and reset
	input  wire       mclk_i,
	input  wire       rst_n_i,
	// count control
	input  wire [1:0] mode_i,
	input  wire       low_tick_i,
	input  wire       high_tick_i,
	input  wire       split_i,
	// software writes
	input  wire       wr_low_i,
	input  wire       wr_high_i,
	input  wire [7:0] wdata_i,
	// state
	output reg  [7:0] low_q_o,
	output reg  [7:0] high_q_o,
	output reg        ovf_low_o,
	output reg        ovf_high_o
);
	reg [7:0] low_d;
	reg [7:0] high_d;
	reg       ovf_low_d;
	reg       ovf_high_d;

	always @*
	begin
		low_d      = low_q_o;
		high_d     = high_q_o;
		ovf_low_d  = 1'b0;
		ovf_high_d = 1'b0;
		case (mode_i)
		`DTC_M_PRESC:
		begin
			if (low_tick_i)
			begin
				// upper three low bits kept as software left them
				if (low_q_o[4:0] == `DTC_PRESC_MAX)
				begin
					low_d  = {low_q_o[7:5], 5'h00};
					high_d = high_q_o + 8'h01;
					ovf_high_d = (high_q_o == 8'hff);
				end
				else
					low_d = {low_q_o[7:5], low_q_o[4:0] + 5'h01};
			end
		end
		`DTC_M_WIDE:
		begin
			if (low_tick_i)
			begin
				low_d = low_q_o + 8'h01;
				if (low_q_o == 8'hff)
				begin
					high_d = high_q_o + 8'h01;
					ovf_high_d = (high_q_o == 8'hff);
				end
			end
		end
		`DTC_M_RELOAD:
		begin
			if (low_tick_i)
			begin
				if (low_q_o == 8'hff)
				begin
					low_d = high_q_o;
					ovf_low_d = 1'b1;
				end
				else
					low_d = low_q_o + 8'h01;
			end
		end
		default:
		begin
			// split for unit 0; a plain hold for unit 1
			if (split_i)
			begin
				if (low_tick_i)
				begin
					low_d = low_q_o + 8'h01;
					ovf_low_d = (low_q_o == 8'hff);
				end
				if (high_tick_i)
				begin
					high_d = high_q_o + 8'h01;
					ovf_high_d = (high_q_o == 8'hff);
				end
			end
		end
		endcase
		// software write to a byte wins over the count in that cycle
		if (wr_low_i)
			low_d = wdata_i;
		if (wr_high_i)
			high_d = wdata_i;
	end

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			low_q_o    <= `DTC_CNT_RESET;
			high_q_o   <= `DTC_CNT_RESET;
			ovf_low_o  <= 1'b0;
			ovf_high_o <= 1'b0;
		end
		else
		begin
			low_q_o    <= low_d;
			high_q_o   <= high_d;
			ovf_low_o  <= ovf_low_d;
			ovf_high_o <= ovf_high_d;
		end
	end
endmodule
`default_nettype wire

/* bench/dtc_top_props.sv */
// port assertions for the dual timer/counter
`default_nettype none
module dtc_top_props
(
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// register bus
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// flags
	input wire logic        timer0_vector_ack_i,
	input wire logic        timer1_vector_ack_i,
	input wire logic        timer0_overflow_flag_o,
	input wire logic        timer1_overflow_flag_o,
	input wire logic        timer1_overflow_pulse_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic ctrl_wr = avs_write_i && avs_address_i == 8'h88;
	wire logic mapped  = avs_address_i >= 8'h88 && avs_address_i <= 8'h8d;
	sequence s_bad_rd;
		avs_read_i && !avs_waitrequest_o && !mapped;
	endsequence
	// split mode sets flag 1 without the pulse, so no ack is given there
	sequence s_ack1;
		timer1_vector_ack_i && !timer1_overflow_pulse_o && !avs_write_i;
	endsequence
	a_wait_rd_only: assert property (!avs_read_i |-> !avs_waitrequest_o)
		else $error("waitrequest high without read");
	a_rd_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("read waited more than one cycle");
	a_rd_upper: assert property (avs_readdata_o[31:8] == 24'h0)
		else $error("readdata upper bits set");
	a_rd_stands: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("readdata moved");
	a_unmapped_zero: assert property (s_bad_rd |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_flag0_sticky: assert property (timer0_overflow_flag_o && !timer0_vector_ack_i && !ctrl_wr
		|=> timer0_overflow_flag_o)
		else $error("flag 0 dropped");
	a_flag1_sticky: assert property (timer1_overflow_flag_o && !timer1_vector_ack_i && !ctrl_wr
		|=> timer1_overflow_flag_o)
		else $error("flag 1 dropped");
	a_pulse_sets_flag: assert property (timer1_overflow_pulse_o |=> timer1_overflow_flag_o)
		else $error("pulse without flag");
	a_ack_clears: assert property (s_ack1 |=> !timer1_overflow_flag_o)
		else $error("ack left flag 1");
endmodule
bind dtc_top dtc_top_props i_dtc_top_props (.*);
`default_nettype wire

/* bench/dtc_pin_model.sv */
// event pin source for the timer/counter
`default_nettype none
module dtc_pin_model
(
	// clock and control
	input  wire logic       mclk_i,
	input  wire logic       en_i,
	// pin and tally of falls
	output var  logic       ev_o,
	output var  logic [7:0] falls_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_q = 2'h0;
	initial ev_o = 1'b0;
	initial falls_o = 8'h0;
	// two cycles per level, above the one-cycle minimum
	always @(posedge mclk_i)
	begin
		ph_q <= en_i ? ph_q + 2'h1 : 2'h0;
		ev_o <= en_i & ph_q[1];
		if (ev_o & ~(en_i & ph_q[1]))
			falls_o <= falls_o + 8'h1;
	end
endmodule
`default_nettype wire

/* bench/dtc_top_test.sv */
// self-checking bench for the dual timer/counter
`default_nettype none
module dtc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  avs_address_i = 8'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic        ext_irq_pin_a_i = 1'b0;
	logic        ext_irq_pin_b_i = 1'b0;
	logic        timer0_vector_ack_i = 1'b0;
	logic        timer1_vector_ack_i = 1'b0;
	logic        en = 1'b0;
	logic [7:0]  m;
	logic [7:0]  falls;
	logic [23:0] note_q[$];
	int          err_total = 0;
	int          checks_done = 0;
	wire logic [31:0] avs_readdata_o;
	wire logic   avs_waitrequest_o;
	wire logic   timer0_event_input_i;
	wire logic   timer1_event_input_i = timer0_event_input_i;
	wire logic   timer0_overflow_flag_o;
	wire logic   timer1_overflow_flag_o;
	wire logic   timer1_overflow_pulse_o;
	always #4 mclk_i = ~mclk_i;
	dtc_top i_dtc_top (.*);
	dtc_pin_model i_dtc_pin_model (.mclk_i(mclk_i), .en_i(en),
		.ev_o(timer0_event_input_i), .falls_o(falls));
	// read data are taken at the edge where waitrequest is seen low
	always @(posedge mclk_i)
	begin
		if (avs_read_i && (avs_waitrequest_o === 1'b0))
		begin
			checks_done++;
			if (((avs_readdata_o >= note_q[0][15:8]) && (avs_readdata_o <= note_q[0][7:0])) !== 1'b1)
			begin
				err_total++;
				$display("unexpected readdata at %h: expected %h..%h, seen %h",
					note_q[0][23:16], note_q[0][15:8], note_q[0][7:0], avs_readdata_o);
			end
			void'(note_q.pop_front());
		end
	end
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic [3:0] be);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_byteenable_i <= be;
		avs_write_i <= w;
		avs_read_i <= ~w;
		@(posedge mclk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge mclk_i);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, d, 1'b1, 4'hf);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		note_q.push_back({a, lo, hi});
		bus(a, 8'h0, 1'b0, 4'hf);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic ack;
		timer0_vector_ack_i <= 1'b1;
		timer1_vector_ack_i <= 1'b1;
		@(posedge mclk_i);
		timer0_vector_ack_i <= 1'b0;
		timer1_vector_ack_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic fin(input int n);
		$display("test %0d done", n);
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(32'h2602b077));
		idle(12);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		for (int a = 'h88; a <= 'h8d; a++)
			rd(a[7:0], 8'h0, 8'h0);
		wr(8'h90, 8'h5a);
		rd(8'h90, 8'h0, 8'h0);
		m = 8'($urandom);
		wr(8'h89, m);
		bus(8'h89, ~m, 1'b1, 4'he);
		rd(8'h89, m, m);
		fin(1);
		wr(8'h89, 8'h99);
		wr(8'h88, 8'h50);
		idle(10);
		rd(8'h8a, 8'h0, 8'h0);
		ext_irq_pin_a_i <= 1'b1;
		idle(10);
		ext_irq_pin_a_i <= 1'b0;
		rd(8'h8b, 8'h0, 8'h0);
		wr(8'h89, 8'h19);
		idle(10);
		wr(8'h88, 8'h00);
		rd(8'h8b, 8'h09, 8'h0e);
		rd(8'h8a, 8'h08, 8'h0c);
		fin(2);
		wr(8'h89, 8'h55);
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h88, 8'h50);
		en <= 1'b1;
		idle(40);
		en <= 1'b0;
		idle(4);
		rd(8'h8a, falls, falls);
		rd(8'h8b, falls, falls);
		fin(3);
		wr(8'h89, 8'h20);
		wr(8'h8d, 8'hff);
		wr(8'h8b, 8'hff);
		wr(8'h88, 8'h40);
		idle(5);
		wr(8'h89, 8'h30);
		rd(8'h8b, 8'hff, 8'hff);
		rd(8'h88, 8'hc0, 8'hc0);
		ack();
		rd(8'h88, 8'h40, 8'h40);
		wr(8'h8b, 8'h05);
		idle(5);
		rd(8'h8b, 8'h05, 8'h05);
		fin(4);
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h08);
		wr(8'h8a, 8'h1f);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h10);
		ext_irq_pin_a_i <= 1'b1;
		idle(2);
		ext_irq_pin_a_i <= 1'b0;
		rd(8'h8c, 8'h00, 8'h00);
		rd(8'h8a, 8'h00, 8'h03);
		rd(8'h88, 8'h30, 8'h30);
		ack();
		rd(8'h88, 8'h10, 8'h10);
		fin(5);
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h03);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'hf0);
		wr(8'h88, 8'h40);
		idle(20);
		rd(8'h88, 8'hc0, 8'hc0);
		wr(8'h88, 8'h00);
		rd(8'h8c, 8'h05, 8'h0b);
		rd(8'h8a, 8'h00, 8'h00);
		wr(8'h88, 8'h10);
		idle(10);
		wr(8'h88, 8'h00);
		rd(8'h8a, 8'h09, 8'h0e);
		fin(6);
		idle(3);
		end_of_test();
	end
endmodule
`default_nettype wire
